// ===== port_power_strap_control.sv
// Behaviour
// - Power enable low removes, high supplies port
// - Combined pin: open-drain enable plus overcurrent sense
// - Charge strap 0 unsupported, 1 supported
// - Straps captured at every reset release, held
// - Local supply sampled in configuration state
// - Power decision fixed unless dynamic switching enabled
// - Dynamic register resets 0xC1, 0x41 enables
// - Local detect in use: fixed straps ignored
// - Local supply low means bus powered
`timescale 1ns/10ps
`default_nettype none

module port_power_strap_control (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic port1_power_request,
  input wire logic port2_power_request,
  input wire logic port3_power_request,
  output logic port1_power_enable,
  output logic port2_power_enable,
  output logic port3_power_enable,
  input wire logic port1_combined_ctl_in,
  input wire logic port2_combined_ctl_in,
  input wire logic port3_combined_ctl_in,
  output logic port1_combined_ctl_out,
  output logic port2_combined_ctl_out,
  output logic port3_combined_ctl_out,
  output logic port1_combined_ctl_oe,
  output logic port2_combined_ctl_oe,
  output logic port3_combined_ctl_oe,
  input wire logic port1_overcurrent_sense_n,
  input wire logic port2_overcurrent_sense_n,
  input wire logic port3_overcurrent_sense_n,
  input wire logic port1_charge_support_strap,
  input wire logic port2_charge_support_strap,
  input wire logic port3_charge_support_strap,
  input wire logic [1:0] fixed_device_straps,
  input wire logic local_supply_detect,
  output logic port1_charge_supported,
  output logic port2_charge_supported,
  output logic port3_charge_supported,
  output logic port1_overcurrent_event,
  output logic port2_overcurrent_event,
  output logic port3_overcurrent_event,
  output logic [2:0] port_non_removable,
  output logic self_powered,
  output logic config_done,
  input wire logic [15:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Input filter

  logic [port_power_strap_pkg::NUM_SYNC_INPUTS-1:0] raw_in;
  logic [port_power_strap_pkg::NUM_SYNC_INPUTS-1:0] filt_reg;

  assign raw_in = {fixed_device_straps, local_supply_detect,
                   port3_charge_support_strap, port2_charge_support_strap,
                   port1_charge_support_strap,
                   port3_overcurrent_sense_n, port2_overcurrent_sense_n,
                   port1_overcurrent_sense_n,
                   port3_combined_ctl_in, port2_combined_ctl_in,
                   port1_combined_ctl_in};

  genvar gi;
  generate
    for (gi = 0; gi < port_power_strap_pkg::NUM_SYNC_INPUTS; gi++) begin : g_sync
      logic [port_power_strap_pkg::SYNC_STAGES-1:0] sync_reg;
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          sync_reg <= '0;
        end else begin
          sync_reg <= {sync_reg[1:0], raw_in[gi]};
        end
      end
      // A change counts only once the second and third stages agree
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          filt_reg[gi] <= 1'b0;
        end else if (sync_reg[1] == sync_reg[2]) begin
          filt_reg[gi] <= sync_reg[2];
        end
      end
    end
  endgenerate

  wire logic [2:0] ctl_in_f = filt_reg[2:0];
  wire logic [2:0] ocs_n_f = filt_reg[5:3];
  wire logic [2:0] charge_strap_f = filt_reg[8:6];
  wire logic local_f = filt_reg[9];
  wire logic [1:0] fixed_f = filt_reg[11:10];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration sequence after reset release

  port_power_strap_pkg::cfg_state_e state_reg;
  logic [2:0] settle_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= port_power_strap_pkg::ST_CAPTURE;
    end else begin
      case (state_reg)
        port_power_strap_pkg::ST_CAPTURE: begin
          if (settle_reg == port_power_strap_pkg::STRAP_SETTLE_CYCLES) begin
            state_reg <= port_power_strap_pkg::ST_CONFIG;
          end
        end
        port_power_strap_pkg::ST_CONFIG: state_reg <= port_power_strap_pkg::ST_RUN;
        port_power_strap_pkg::ST_RUN: state_reg <= port_power_strap_pkg::ST_RUN;
        default: state_reg <= port_power_strap_pkg::ST_CAPTURE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      settle_reg <= '0;
    end else if (state_reg == port_power_strap_pkg::ST_CAPTURE) begin
      settle_reg <= settle_reg + 3'h1;
    end
  end

  // Straps are caught once per reset release, so POR and the external
  // reset both come through resetn and both re-capture
  logic [2:0] charge_reg;
  logic [1:0] fixed_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      charge_reg <= '0;
      fixed_reg <= '0;
    end else if (state_reg == port_power_strap_pkg::ST_CAPTURE &&
                 settle_reg == port_power_strap_pkg::STRAP_SETTLE_CYCLES) begin
      charge_reg <= charge_strap_f;
      fixed_reg <= fixed_f;
    end
  end

  assign {port3_charge_supported, port2_charge_supported,
          port1_charge_supported} = charge_reg;
  assign config_done = (state_reg == port_power_strap_pkg::ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] dyn_power_reg;
  logic [7:0] port_mode_reg;
  logic [7:0] fixed_cfg_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dyn_power_reg <= port_power_strap_pkg::DYN_POWER_RESET;
      port_mode_reg <= port_power_strap_pkg::PORT_MODE_RESET;
      fixed_cfg_reg <= port_power_strap_pkg::FIXED_CFG_RESET;
    end else if (cfg_wr) begin
      case (cfg_addr)
        port_power_strap_pkg::DYN_POWER_ADDR: dyn_power_reg <= cfg_wdata;
        port_power_strap_pkg::PORT_MODE_ADDR: port_mode_reg <= cfg_wdata;
        port_power_strap_pkg::FIXED_CFG_ADDR: fixed_cfg_reg <= cfg_wdata;
        default: begin end
      endcase
    end
  end

  logic [2:0] combined_mode;

  assign combined_mode = port_mode_reg[port_power_strap_pkg::PORT_MODE_COMBINED_LSB +: 3];
  wire logic local_in_use = port_mode_reg[port_power_strap_pkg::PORT_MODE_LOCAL_USE_BIT];
  // Only the exact enable value switches; anything else stays static
  wire logic dyn_enabled = (dyn_power_reg == port_power_strap_pkg::DYN_POWER_ENABLE);

  ////////////////////////////////////////////////////////////////////////////
  // Power source decision

  logic self_powered_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      self_powered_reg <= 1'b0;
    end else if (state_reg == port_power_strap_pkg::ST_CONFIG) begin
      self_powered_reg <= local_f;
    end else if (state_reg == port_power_strap_pkg::ST_RUN && dyn_enabled) begin
      self_powered_reg <= local_f;
    end
  end

  assign self_powered = self_powered_reg;

  // Fixed straps decode to a count of non-removable ports from port 1 up
  logic [2:0] strap_non_rem;

  always_comb begin
    case (fixed_reg)
      2'b01: strap_non_rem = 3'b001;
      2'b10: strap_non_rem = 3'b011;
      2'b11: strap_non_rem = 3'b111;
      default: strap_non_rem = 3'b000;
    endcase
  end

  assign port_non_removable = local_in_use ? fixed_cfg_reg[2:0] : strap_non_rem;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port power and over-current

  logic [2:0] enable;
  logic [2:0] oc_reg;
  logic [2:0] oc_event_reg;
  logic [2:0] pin_oe;

  wire logic [2:0] request = {port3_power_request, port2_power_request, port1_power_request};

  generate
    for (gi = 0; gi < port_power_strap_pkg::NUM_PORTS; gi++) begin : g_port
      logic sense_n;
      logic oc_hit;
      logic [port_power_strap_pkg::SYNC_STAGES:0] release_hist_reg;
      // Filter lags a release; sensing early would read power-up as a fault
      assign sense_n = combined_mode[gi] ? (ctl_in_f[gi] | ~&release_hist_reg)
                                         : ocs_n_f[gi];
      assign oc_hit = enable[gi] & ~sense_n;
      // Power stays off until configuration ends so straps read cleanly
      assign enable[gi] = config_done & request[gi] & ~oc_reg[gi];
      // Open drain: pull low to disable, release so the pull-up enables
      assign pin_oe[gi] = combined_mode[gi] & config_done & ~enable[gi];

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          release_hist_reg <= '0;
        end else begin
          release_hist_reg <= {release_hist_reg[port_power_strap_pkg::SYNC_STAGES-1:0],
                               enable[gi]};
        end
      end

      // Latched until the hub drops the request; a new hit wins
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          oc_reg[gi] <= 1'b0;
        end else if (oc_hit) begin
          oc_reg[gi] <= 1'b1;
        end else if (!request[gi]) begin
          oc_reg[gi] <= 1'b0;
        end
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          oc_event_reg[gi] <= 1'b0;
        end else begin
          oc_event_reg[gi] <= oc_hit;
        end
      end
    end
  endgenerate

  assign {port3_power_enable, port2_power_enable, port1_power_enable} = enable;
  assign {port3_combined_ctl_out, port2_combined_ctl_out, port1_combined_ctl_out} = 3'b000;
  assign {port3_combined_ctl_oe, port2_combined_ctl_oe, port1_combined_ctl_oe} = pin_oe;
  assign {port3_overcurrent_event, port2_overcurrent_event,
          port1_overcurrent_event} = oc_event_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[port_power_strap_pkg::STATUS_OVERCURRENT_LSB +: 3] = oc_reg;
    status[port_power_strap_pkg::STATUS_SELF_POWERED_BIT] = self_powered_reg;
    status[port_power_strap_pkg::STATUS_CHARGE_LSB +: 3] = charge_reg;
    status[port_power_strap_pkg::STATUS_LOCAL_SUPPLY_BIT] = local_f;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_addr)
        port_power_strap_pkg::DYN_POWER_ADDR: cfg_rdata <= dyn_power_reg;
        port_power_strap_pkg::PORT_MODE_ADDR: cfg_rdata <= port_mode_reg;
        port_power_strap_pkg::FIXED_CFG_ADDR: cfg_rdata <= fixed_cfg_reg;
        port_power_strap_pkg::STATUS_ADDR: cfg_rdata <= status;
        default: cfg_rdata <= 8'h00;
      endcase
    end
  end

endmodule : port_power_strap_control

`default_nettype wire

// ===== port_power_strap_pkg.sv
package port_power_strap_pkg;

  localparam int NUM_PORTS = 3;

  // Configuration register offsets
  localparam logic [15:0] DYN_POWER_ADDR = 16'h4134;
  localparam logic [15:0] PORT_MODE_ADDR = 16'h4135;
  localparam logic [15:0] FIXED_CFG_ADDR = 16'h4136;
  localparam logic [15:0] STATUS_ADDR = 16'h4137;

  // Dynamic power configuration values
  localparam logic [7:0] DYN_POWER_RESET = 8'hc1;
  localparam logic [7:0] DYN_POWER_ENABLE = 8'h41;

  // Port mode register fields
  localparam int PORT_MODE_COMBINED_LSB = 0;
  localparam int PORT_MODE_LOCAL_USE_BIT = 3;
  localparam logic [7:0] PORT_MODE_RESET = 8'h00;
  localparam logic [7:0] FIXED_CFG_RESET = 8'h00;

  // Status register fields
  localparam int STATUS_OVERCURRENT_LSB = 0;
  localparam int STATUS_SELF_POWERED_BIT = 3;
  localparam int STATUS_CHARGE_LSB = 4;
  localparam int STATUS_LOCAL_SUPPLY_BIT = 7;

  // Input filter: three flops, second and third must agree
  localparam int SYNC_STAGES = 3;
  localparam int NUM_SYNC_INPUTS = 12;

  // Cycles after reset release before the filtered straps are trusted
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h5;

  typedef enum logic [2:0] {
    ST_CAPTURE = 3'b001,
    ST_CONFIG = 3'b010,
    ST_RUN = 3'b100
  } cfg_state_e;

endpackage : port_power_strap_pkg

// ===== port_power_switch_model.sv
`timescale 1ns/10ps
`default_nettype none

module port_power_switch_model (
  input wire logic [2:0] power_on,
  input wire logic [2:0] pull_low,
  input wire logic [2:0] fault,
  output logic [2:0] flag_n,
  output logic [2:0] pin_level
);
  // A switch only flags over-current while it carries load
  assign flag_n = ~(fault & power_on);
  // Pulled-up shared pin: either side may pull it low
  assign pin_level = ~(pull_low | (fault & power_on));
endmodule : port_power_switch_model

`default_nettype wire

// ===== port_power_strap_control_checker.sv
`timescale 1ns/10ps
`default_nettype none

module port_power_strap_control_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic port1_power_request,
  input wire logic port1_power_enable,
  input wire logic port2_power_enable,
  input wire logic port3_power_enable,
  input wire logic port1_combined_ctl_out,
  input wire logic port1_combined_ctl_oe,
  input wire logic port1_overcurrent_event,
  input wire logic port1_charge_supported,
  input wire logic port2_charge_supported,
  input wire logic port3_charge_supported,
  input wire logic [2:0] port_non_removable,
  input wire logic config_done,
  input wire logic cfg_wr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  off_before_cfg_a: assert property (
    !config_done |-> !(port1_power_enable || port2_power_enable || port3_power_enable))
    else $error("port powered before configuration");
  en_needs_req_a: assert property (
    port1_power_enable |-> port1_power_request) else $error("power without request");
  od_never_high_a: assert property (
    !port1_combined_ctl_out) else $error("open-drain pin driven high");
  od_pull_off_a: assert property (
    port1_combined_ctl_oe |-> !port1_power_enable) else $error("pin pulled while powered");
  oc_event_a: assert property (
    config_done && port1_power_request && $fell(port1_power_enable)
    |-> ##[0:1] port1_overcurrent_event) else $error("over-current not flagged");
  charge_held_a: assert property (
    config_done && $past(config_done) |-> $stable({port1_charge_supported,
    port2_charge_supported, port3_charge_supported})) else $error("straps changed");
  nrem_held_a: assert property (
    config_done && $past(config_done) && !$past(cfg_wr) |-> $stable(port_non_removable))
    else $error("non-removable changed without write");
  done_bound_a: assert property (
    !config_done |-> ##[1:16] config_done) else $error("configuration never ends");
  done_held_a: assert property (
    config_done |=> config_done) else $error("configuration state left");
endmodule : port_power_strap_control_checker

bind port_power_strap_control port_power_strap_control_checker
  port_power_strap_control_checker_inst (.*);

`default_nettype wire

// ===== port_power_strap_control_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end

module port_power_strap_control_test;
  logic sys_clk = 0, resetn = 0, loc = 0, wr = 0, rd = 0, s;
  logic [2:0] req = 0, fault = 0, cs = 3'b101;
  logic [1:0] fix = 2'b10;
  logic [15:0] addr = 0;
  logic [7:0] wd = 0, r;
  wire [2:0] en, oe, od, ocs, pin, cap, ev, nrem;
  wire sp, done;
  wire [7:0] rdata;
  int error_cnt = 0, num_checks = 0, cyc = 0;

  port_power_strap_control port_power_strap_control_inst (
    .sys_clk(sys_clk), .resetn(resetn), .port1_power_request(req[0]),
    .port2_power_request(req[1]), .port3_power_request(req[2]),
    .port1_power_enable(en[0]), .port2_power_enable(en[1]), .port3_power_enable(en[2]),
    .port1_combined_ctl_in(pin[0]), .port2_combined_ctl_in(pin[1]),
    .port3_combined_ctl_in(pin[2]), .port1_combined_ctl_out(od[0]),
    .port2_combined_ctl_out(od[1]), .port3_combined_ctl_out(od[2]),
    .port1_combined_ctl_oe(oe[0]), .port2_combined_ctl_oe(oe[1]),
    .port3_combined_ctl_oe(oe[2]), .port1_overcurrent_sense_n(ocs[0]),
    .port2_overcurrent_sense_n(ocs[1]), .port3_overcurrent_sense_n(ocs[2]),
    .port1_charge_support_strap(cs[0]), .port2_charge_support_strap(cs[1]),
    .port3_charge_support_strap(cs[2]), .fixed_device_straps(fix),
    .local_supply_detect(loc), .port1_charge_supported(cap[0]),
    .port2_charge_supported(cap[1]), .port3_charge_supported(cap[2]),
    .port1_overcurrent_event(ev[0]), .port2_overcurrent_event(ev[1]),
    .port3_overcurrent_event(ev[2]), .port_non_removable(nrem), .self_powered(sp),
    .config_done(done), .cfg_addr(addr), .cfg_wr(wr), .cfg_rd(rd), .cfg_wdata(wd),
    .cfg_rdata(rdata));

  port_power_switch_model port_power_switch_model_inst (
    .power_on(en), .pull_low(oe), .fault(fault), .flag_n(ocs), .pin_level(pin));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Bounds a hang; the whole run needs well under 500 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : step

  task automatic do_reset();
    resetn = 0;
    step(10);
    resetn = 1;
    for (int i = 0; i < 20 && done !== 1'b1; i++) step(1);
    `CHK("config_done", 1'b1, done)
  endtask : do_reset

  task automatic cfg_w(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1;
    step(1);
    wr = 0;
  endtask : cfg_w

  task automatic cfg_r(input logic [15:0] a, output logic [7:0] d);
    addr = a;
    rd = 1;
    step(1);
    rd = 0;
    d = rdata;
  endtask : cfg_r

  task automatic t_straps();
    cfg_r(port_power_strap_pkg::DYN_POWER_ADDR, r);
    `CHK("dyn_reset", 8'hc1, r)
    cfg_w(16'h4000, 8'hff);
    cfg_r(16'h4000, r);
    `CHK("unmapped", 8'h00, r)
    `CHK("charge", 3'b101, cap)
    `CHK("self_pwr", 1'b0, sp)
    cs = 3'b010;
    loc = 1;
    do_reset();
    `CHK("charge_new", 3'b010, cap)
    `CHK("self_pwr_new", 1'b1, sp)
    cfg_r(port_power_strap_pkg::STATUS_ADDR, r);
    `CHK("status", 8'ha8, r)
    loc = 0;
    step(10);
    `CHK("self_pwr_held", 1'b1, sp)
    $display("straps test done");
  endtask : t_straps

  task automatic t_dyn();
    cfg_w(port_power_strap_pkg::DYN_POWER_ADDR, 8'h41);
    cfg_r(port_power_strap_pkg::DYN_POWER_ADDR, r);
    `CHK("dyn_rd", 8'h41, r)
    step(8);
    `CHK("dyn_bus", 1'b0, sp)
    loc = 1;
    step(8);
    `CHK("dyn_self", 1'b1, sp)
    cfg_w(port_power_strap_pkg::DYN_POWER_ADDR, 8'hc1);
    loc = 0;
    step(8);
    `CHK("static_again", 1'b1, sp)
    $display("dynamic test done");
  endtask : t_dyn

  task automatic t_power();
    for (int p = 0; p < 3; p++) begin
      req[p] = 1;
      step(1);
      `CHK("enable_on", 3'(1 << p), en)
      fault[p] = 1;
      s = 0;
      repeat (12) begin
        step(1);
        s = s | ev[p];
      end
      `CHK("oc_cut", 1'b0, en[p])
      `CHK("oc_event", 1'b1, s)
      fault[p] = 0;
      step(6);
      `CHK("oc_latched", 1'b0, en[p])
      req[p] = 0;
      step(2);
      req[p] = 1;
      step(1);
      `CHK("oc_cleared", 1'b1, en[p])
      req[p] = 0;
      step(1);
      `CHK("enable_off", 3'b000, en)
    end
    $display("power test done");
  endtask : t_power

  task automatic t_comb();
    cfg_w(port_power_strap_pkg::PORT_MODE_ADDR, 8'h07);
    step(1);
    `CHK("pulled_low", 3'b111, oe)
    req = 3'b111;
    step(1);
    `CHK("released", 3'b000, oe)
    `CHK("never_high", 3'b000, od)
    fault = 3'b010;
    step(12);
    `CHK("pin_oc", 3'b101, en)
    `CHK("pin_oe", 3'b010, oe)
    fault = 0;
    req = 0;
    step(2);
    cfg_w(port_power_strap_pkg::PORT_MODE_ADDR, 8'h00);
    $display("combined test done");
  endtask : t_comb

  task automatic t_nonrem();
    `CHK("nrem_strap", 3'b011, nrem)
    fix = 2'b11;
    cfg_w(port_power_strap_pkg::FIXED_CFG_ADDR, 8'h05);
    step(1);
    cfg_w(port_power_strap_pkg::PORT_MODE_ADDR, 8'h08);
    step(1);
    `CHK("nrem_reg", 3'b101, nrem)
    $display("non-removable test done");
  endtask : t_nonrem

  initial begin
    do_reset();
    t_straps();
    t_dyn();
    t_power();
    t_comb();
    t_nonrem();
    give_verdict();
  end
endmodule : port_power_strap_control_test

`default_nettype wire
